// ==== verilog/efdt_extra_dma.sv ====
// Extra FIFO and its busmaster transfer engine with AXI4-Lite registers
//
// Function
// - Own DMA engine, independent of main path
// - One FIFO holds slow data and timestamps
// - Combined command codes executed together, except start with poll; a wait sent with a start acts only if DMA is already active
// - Start command begins DMA mode transfer
// - Wait ends on end, block or timeout
// - Stop aborts transfer, data invalidated
// - Poll reads without DMA; modes exclusive
// - Block ready flag on notify-size block
// - End flag only when notify is zero
// - Overrun flag on FIFO overflow during transfer
// - Error flag on internal transfer fault
// - Card to host only, no offset
// - Notify zero reports only at end
// - User length gives newly filled bytes
// - User position gives start of data
// - Start clears user length, card length full
// - User length steps by notify size
// - Scatter transfer continues until buffer used
// - Event pulse toward host on new data
// - FIFO overrun halts transfer at once
// - Entries are 64-bit, 8-byte steps
`timescale 1ns/1ps
module efdt_extra_dma
   import efdt_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic awvalid,
   output logic awready,
   input wire logic [11:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [11:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic xfifoValid,
   input wire logic xfifoKind,
   input wire logic [63:0] xfifoData,
   output logic dmaValid,
   input wire logic dmaReady,
   output logic [31:0] dmaAddr,
   output logic [63:0] dmaData,
   output logic dmaStream,
   input wire logic dmaError,
   output logic hostEvent
);
   ////////////////////////////////////////////////////////////////////////////
   logic [9:0] awIdx;
   logic [31:0] wDataQ;
   logic [3:0] wStrbQ;
   logic wrGo;
   logic [31:0] wVal;
   logic [9:0] rdIdx;
   logic dmaActive;
   logic pollActive;
   logic waitBusy;
   logic waitTimedOut;
   logic flagBlock;
   logic flagEnd;
   logic flagOverrun;
   logic flagError;
   logic [31:0] notifySize;
   logic [31:0] timeoutMs;
   logic [31:0] msTick;
   logic [31:0] msCount;
   logic [64:0] fifoMem [FIFO_DEPTH];
   logic [FIFO_AW:0] wrPtr;
   logic [FIFO_AW:0] rdPtr;
   logic fifoEmpty;
   logic fifoFull;
   logic [64:0] head;
   logic push;
   logic pop;
   logic pollPop;
   logic canLoad;
   logic cmdWr;
   logic startReq;
   logic pollReq;
   logic stopGo;
   logic waitReq;
   logic modeClash;
   logic startGo;
   logic pollGo;
   logic overrunEv;
   logic errorEv;
   logic timeoutHit;
   logic waitClr;
   logic [NUM_STREAMS-1:0] notifyHit;
   logic [NUM_STREAMS-1:0] endHit;
   logic [NUM_STREAMS-1:0] roomOk;
   logic [31:0] statusWord;
   logic [31:0] next_rdata;
   logic rdOk;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write side: address and data taken in either order
   assign wrGo = !awready && !wready && !bvalid;

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wVal[8*i +: 8] = wStrbQ[i] ? wDataQ[8*i +: 8] : 8'h00;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         awIdx <= '0;
         wDataQ <= RESET_WORD;
         wStrbQ <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awIdx <= awaddr[11:2];
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wDataQ <= wdata;
            wStrbQ <= wstrb;
            wready <= 1'b0;
         end
         if (wrGo) begin
            bvalid <= 1'b1;
            unique case (awIdx)
               IDX_COMMAND, IDX_NOTIFY, IDX_TIMEOUT, IDX_SLOW_CARD_LEN, IDX_SLOW_BUF_LEN,
               IDX_SLOW_BASE, IDX_STAMP_CARD_LEN, IDX_STAMP_BUF_LEN, IDX_STAMP_BASE:
                  bresp <= RESP_OKAY;
               default:
                  bresp <= RESP_SLVERR;
            endcase
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode; codes in one word act together, except start with poll, which is a clash, and wait with start, which needs DMA already active
   assign cmdWr = wrGo && (awIdx == IDX_COMMAND);
   assign stopGo = cmdWr && ((wVal & CMD_EXTRA_STOP) != RESET_WORD);
   assign startReq = cmdWr && ((wVal & CMD_EXTRA_START) != RESET_WORD);
   assign pollReq = cmdWr && ((wVal & CMD_EXTRA_POLL) != RESET_WORD);
   assign waitReq = cmdWr && ((wVal & CMD_EXTRA_WAIT) != RESET_WORD) && dmaActive;
   // A start and a poll never share the path; stop in the same word frees it
   assign modeClash = (startReq && pollReq) || (startReq && pollActive && !stopGo)
      || (pollReq && dmaActive && !stopGo);
   assign startGo = startReq && !modeClash;
   assign pollGo = pollReq && !modeClash;
   assign overrunEv = push == 1'b0 && xfifoValid && (dmaActive || pollActive);
   assign errorEv = (dmaError && dmaActive) || modeClash;

   always_ff @(posedge mclk) begin
      if (srst) begin
         dmaActive <= 1'b0;
         pollActive <= 1'b0;
      end else begin
         if (stopGo || overrunEv || errorEv) begin
            dmaActive <= 1'b0;
            pollActive <= 1'b0;
         end
         if (startGo) begin
            dmaActive <= 1'b1;
         end
         if (pollGo) begin
            pollActive <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         notifySize <= RESET_WORD;
         timeoutMs <= RESET_WORD;
      end else if (wrGo) begin
         if (awIdx == IDX_NOTIFY) begin
            notifySize <= wVal;
         end
         if (awIdx == IDX_TIMEOUT) begin
            timeoutMs <= wVal;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status flags; a new start clears them, but a same-cycle event wins
   always_ff @(posedge mclk) begin
      if (srst) begin
         flagBlock <= 1'b0;
         flagEnd <= 1'b0;
         flagOverrun <= 1'b0;
         flagError <= 1'b0;
      end else begin
         flagBlock <= (|notifyHit) || (flagBlock && !startGo);
         flagEnd <= (|endHit) || (flagEnd && !startGo);
         flagOverrun <= overrunEv || (flagOverrun && !startGo);
         flagError <= errorEv || (flagError && !startGo);
      end
   end

   // One-cycle event so host software can sleep rather than spin
   always_ff @(posedge mclk) begin
      if (srst) begin
         hostEvent <= 1'b0;
      end else begin
         hostEvent <= (|notifyHit) || (|endHit);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wait command: released by new data, end, fault or timeout
   assign timeoutHit = waitBusy && (timeoutMs != RESET_WORD) && (msCount >= timeoutMs);
   assign waitClr = (|notifyHit) || (|endHit) || overrunEv || errorEv || timeoutHit
      || stopGo || !dmaActive;

   always_ff @(posedge mclk) begin
      if (srst) begin
         waitBusy <= 1'b0;
         waitTimedOut <= 1'b0;
         msTick <= RESET_WORD;
         msCount <= RESET_WORD;
      end else begin
         if (waitReq) begin
            waitBusy <= 1'b1;
            waitTimedOut <= 1'b0;
            msTick <= RESET_WORD;
            msCount <= RESET_WORD;
         end else if (waitBusy) begin
            if (waitClr) begin
               waitBusy <= 1'b0;
            end
            if (timeoutHit) begin
               waitTimedOut <= 1'b1;
            end
            if (msTick == 32'(MS_CYCLES - 1)) begin
               msTick <= RESET_WORD;
               msCount <= msCount + 32'h0000_0001;
            end else begin
               msTick <= msTick + 32'h0000_0001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared extra FIFO; the source cannot stall, so a full FIFO overruns
   assign fifoEmpty = (wrPtr == rdPtr);
   assign fifoFull = (wrPtr[FIFO_AW] != rdPtr[FIFO_AW])
      && (wrPtr[FIFO_AW-1:0] == rdPtr[FIFO_AW-1:0]);
   assign head = fifoMem[rdPtr[FIFO_AW-1:0]];
   assign push = xfifoValid && !fifoFull;
   assign pollPop = arvalid && arready && (araddr[11:2] == IDX_POLL_HI) && pollActive
      && !fifoEmpty;
   // One beat in flight at a time keeps the room check exact
   assign canLoad = dmaActive && !fifoEmpty && !dmaValid && roomOk[head[64]];
   assign pop = canLoad || pollPop;

   always_ff @(posedge mclk) begin
      if (push) begin
         fifoMem[wrPtr[FIFO_AW-1:0]] <= {xfifoKind, xfifoData};
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         if (push) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= rdPtr + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Busmaster write port toward host memory; separate from the main engine
   always_ff @(posedge mclk) begin
      if (srst) begin
         dmaValid <= 1'b0;
         dmaAddr <= RESET_WORD;
         dmaData <= '0;
         dmaStream <= 1'b0;
      end else begin
         if (dmaValid && dmaReady) begin
            dmaValid <= 1'b0;
         end
         if (canLoad) begin
            dmaValid <= 1'b1;
            dmaData <= head[63:0];
            dmaStream <= head[64];
            dmaAddr <= head[64] ? (gStr[1].base + gStr[1].fillPos)
               : (gStr[0].base + gStr[0].fillPos);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per stream buffer handshake
   for (genvar s = 0; s < NUM_STREAMS; s++) begin : gStr
      logic [31:0] bufLen;
      logic [31:0] base;
      logic [31:0] cardAvail;
      logic [31:0] userLen;
      logic [31:0] userPos;
      logic [31:0] fillPos;
      logic [31:0] pending;
      logic [31:0] next_cardAvail;
      logic [31:0] next_userLen;
      logic [31:0] next_userPos;
      logic [31:0] next_fillPos;
      logic [31:0] next_pending;
      logic moved;
      logic relWr;

      assign moved = dmaValid && dmaReady && (dmaStream == 1'(s));
      assign relWr = wrGo && (awIdx == IDX_CARD_LEN[s]);
      assign roomOk[s] = (cardAvail >= ENTRY_BYTES);

      always_comb begin
         next_cardAvail = cardAvail;
         next_userLen = userLen;
         next_userPos = userPos;
         next_fillPos = fillPos;
         next_pending = pending;
         notifyHit[s] = 1'b0;
         endHit[s] = 1'b0;
         if (moved) begin
            next_cardAvail = cardAvail - ENTRY_BYTES;
            next_pending = pending + ENTRY_BYTES;
            next_fillPos = (fillPos + ENTRY_BYTES >= bufLen) ? RESET_WORD
               : fillPos + ENTRY_BYTES;
         end
         if (relWr) begin
            next_cardAvail = next_cardAvail + wVal;
            next_userLen = (wVal > userLen) ? RESET_WORD : userLen - wVal;
            next_userPos = (userPos + wVal >= bufLen) ? userPos + wVal - bufLen
               : userPos + wVal;
         end
         if (notifySize != RESET_WORD && next_pending >= notifySize) begin
            next_userLen = next_userLen + notifySize;
            next_pending = next_pending - notifySize;
            notifyHit[s] = 1'b1;
         end
         if (notifySize == RESET_WORD && moved && next_cardAvail == RESET_WORD) begin
            next_userLen = next_userLen + next_pending;
            next_pending = RESET_WORD;
            endHit[s] = 1'b1;
         end
         if (stopGo) begin
            next_userLen = RESET_WORD;
            next_pending = RESET_WORD;
         end
         if (startGo) begin
            next_cardAvail = bufLen;
            next_userLen = RESET_WORD;
            next_userPos = RESET_WORD;
            next_fillPos = RESET_WORD;
            next_pending = RESET_WORD;
         end
      end

      always_ff @(posedge mclk) begin
         if (srst) begin
            cardAvail <= RESET_WORD;
            userLen <= RESET_WORD;
            userPos <= RESET_WORD;
            fillPos <= RESET_WORD;
            pending <= RESET_WORD;
         end else begin
            cardAvail <= next_cardAvail;
            userLen <= next_userLen;
            userPos <= next_userPos;
            fillPos <= next_fillPos;
            pending <= next_pending;
         end
      end

      always_ff @(posedge mclk) begin
         if (srst) begin
            bufLen <= RESET_WORD;
            base <= RESET_WORD;
         end else if (wrGo) begin
            if (awIdx == IDX_BUF_LEN[s]) begin
               bufLen <= wVal;
            end
            if (awIdx == IDX_BASE[s]) begin
               base <= wVal;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read side
   always_comb begin
      statusWord = RESET_WORD;
      statusWord[ST_DMA_ACTIVE] = dmaActive;
      statusWord[ST_POLL_ACTIVE] = pollActive;
      statusWord[ST_WAIT_BUSY] = waitBusy;
      statusWord[ST_WAIT_TIMEOUT] = waitTimedOut;
      statusWord[ST_HEAD_KIND] = head[64] && !fifoEmpty;
      statusWord[ST_HEAD_VALID] = !fifoEmpty;
      statusWord[ST_BLOCK_READY] = flagBlock;
      statusWord[ST_TRANSFER_END] = flagEnd;
      statusWord[ST_OVERRUN] = flagOverrun;
      statusWord[ST_ERROR] = flagError;
   end

   assign rdIdx = araddr[11:2];

   always_comb begin
      next_rdata = RESET_WORD;
      rdOk = 1'b1;
      unique case (rdIdx)
         IDX_STATUS: next_rdata = statusWord;
         IDX_NOTIFY: next_rdata = notifySize;
         IDX_TIMEOUT: next_rdata = timeoutMs;
         IDX_SLOW_USER_LEN: next_rdata = gStr[0].userLen;
         IDX_SLOW_USER_POS: next_rdata = gStr[0].userPos;
         IDX_SLOW_BUF_LEN: next_rdata = gStr[0].bufLen;
         IDX_SLOW_BASE: next_rdata = gStr[0].base;
         IDX_STAMP_USER_LEN: next_rdata = gStr[1].userLen;
         IDX_STAMP_USER_POS: next_rdata = gStr[1].userPos;
         IDX_STAMP_BUF_LEN: next_rdata = gStr[1].bufLen;
         IDX_STAMP_BASE: next_rdata = gStr[1].base;
         IDX_POLL_LO: next_rdata = fifoEmpty ? RESET_WORD : head[31:0];
         IDX_POLL_HI: next_rdata = fifoEmpty ? RESET_WORD : head[63:32];
         default: rdOk = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= RESET_WORD;
         rresp <= RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= rdOk ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule : efdt_extra_dma

// ==== include/efdt_pkg.sv ====
// Constants for the extra FIFO busmaster transfer block
package efdt_pkg;
   // Register indices; the byte address is four times the index
   localparam int IDX_W = 10;
   localparam logic [9:0] IDX_COMMAND = 10'h064;
   localparam logic [9:0] IDX_STATUS = 10'h06E;
   localparam logic [9:0] IDX_NOTIFY = 10'h0C9;
   localparam logic [9:0] IDX_TIMEOUT = 10'h0CA;
   localparam logic [9:0] IDX_SLOW_USER_LEN = 10'h0D2;
   localparam logic [9:0] IDX_SLOW_USER_POS = 10'h0D3;
   localparam logic [9:0] IDX_SLOW_CARD_LEN = 10'h0D4;
   localparam logic [9:0] IDX_SLOW_BUF_LEN = 10'h0D5;
   localparam logic [9:0] IDX_SLOW_BASE = 10'h0D6;
   localparam logic [9:0] IDX_STAMP_USER_LEN = 10'h0DC;
   localparam logic [9:0] IDX_STAMP_USER_POS = 10'h0DD;
   localparam logic [9:0] IDX_STAMP_CARD_LEN = 10'h0DE;
   localparam logic [9:0] IDX_STAMP_BUF_LEN = 10'h0DF;
   localparam logic [9:0] IDX_STAMP_BASE = 10'h0E0;
   localparam logic [9:0] IDX_POLL_LO = 10'h0E1;
   localparam logic [9:0] IDX_POLL_HI = 10'h0E2;
   // Per stream index tables: element 0 is slow data, element 1 is timestamps
   localparam logic [1:0][9:0] IDX_USER_LEN = {IDX_STAMP_USER_LEN, IDX_SLOW_USER_LEN};
   localparam logic [1:0][9:0] IDX_USER_POS = {IDX_STAMP_USER_POS, IDX_SLOW_USER_POS};
   localparam logic [1:0][9:0] IDX_CARD_LEN = {IDX_STAMP_CARD_LEN, IDX_SLOW_CARD_LEN};
   localparam logic [1:0][9:0] IDX_BUF_LEN = {IDX_STAMP_BUF_LEN, IDX_SLOW_BUF_LEN};
   localparam logic [1:0][9:0] IDX_BASE = {IDX_STAMP_BASE, IDX_SLOW_BASE};
   localparam int NUM_STREAMS = 2;
   // Command codes, combinable in one write
   localparam logic [31:0] CMD_EXTRA_START = 32'h0000_1000;
   localparam logic [31:0] CMD_EXTRA_WAIT = 32'h0020_0000;
   localparam logic [31:0] CMD_EXTRA_STOP = 32'h0040_0000;
   localparam logic [31:0] CMD_EXTRA_POLL = 32'h0080_0000;
   // Status bit positions
   localparam int ST_DMA_ACTIVE = 0;
   localparam int ST_POLL_ACTIVE = 1;
   localparam int ST_WAIT_BUSY = 2;
   localparam int ST_WAIT_TIMEOUT = 3;
   localparam int ST_HEAD_KIND = 4;
   localparam int ST_HEAD_VALID = 5;
   localparam int ST_BLOCK_READY = 12;
   localparam int ST_TRANSFER_END = 13;
   localparam int ST_OVERRUN = 14;
   localparam int ST_ERROR = 15;
   // Data path
   localparam logic [31:0] ENTRY_BYTES = 32'h0000_0008;
   localparam int FIFO_AW = 4;
   localparam int FIFO_DEPTH = 16;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Timing: wait timeout counts in milliseconds
   localparam int MS_NS = 1000000;
   localparam int CLK_NS = 5;
   localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
endpackage : efdt_pkg

// ==== bench/efdt_extra_dma_chk.sv ====
// Port-level checker for the extra FIFO transfer block
`timescale 1ns/1ps
module efdt_extra_dma_chk
   import efdt_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [11:0] awaddr,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [11:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic dmaValid,
   input wire logic dmaReady,
   input wire logic [31:0] dmaAddr,
   input wire logic [63:0] dmaData,
   input wire logic hostEvent
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////
   AST_B_LATENCY: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write response late");
   AST_B_STAND: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   AST_STATUS_RO: assert property (awvalid && awready && awaddr[11:2] == IDX_STATUS
      |-> ##2 bresp == RESP_SLVERR) else $error("status write accepted");
   AST_R_LATENCY: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   AST_R_STAND: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   AST_CMD_WO: assert property (arvalid && arready && araddr[11:2] == IDX_COMMAND
      |=> rresp == RESP_SLVERR && rdata == RESET_WORD) else $error("command readable");
   AST_BEAT_HOLD: assert property (dmaValid && !dmaReady
      |=> dmaValid && $stable(dmaAddr) && $stable(dmaData)) else $error("beat changed");
   AST_BEAT_GAP: assert property (dmaValid && dmaReady |=> !dmaValid)
      else $error("beat repeated");
   AST_EVENT_PULSE: assert property (hostEvent |=> !hostEvent)
      else $error("event too long");
   cover property (dmaValid && dmaReady);
   cover property (hostEvent);
   cover property (bvalid && bresp == RESP_SLVERR);
endmodule : efdt_extra_dma_chk

bind efdt_extra_dma efdt_extra_dma_chk #(.MS_CYCLES(MS_CYCLES)) u_efdt_extra_dma_chk (
   .mclk, .srst, .awvalid, .awready, .awaddr, .wvalid, .wready, .bvalid, .bready, .bresp,
   .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .dmaValid, .dmaReady,
   .dmaAddr, .dmaData, .hostEvent);

// ==== bench/efdt_host_mem.sv ====
// Host memory side of the busmaster path, optionally stalling at random
`timescale 1ns/1ps
module efdt_host_mem (
   input wire logic mclk,
   input wire logic srst,
   input wire logic dmaValid,
   input wire logic stall,
   output logic dmaReady
);
   integer seed = 32'hab7c_365e;
   // Stalls only delay beats; the host never refuses one for good
   always @(posedge mclk) begin
      if (srst) dmaReady <= 1'h0;
      else dmaReady <= dmaValid && (!stall || $random(seed) % 2 == 0);
   end
endmodule : efdt_host_mem

// ==== bench/extra_fifo_dma_transfer_tb_top.sv ====
// Self-checking bench for the extra FIFO transfer block
`timescale 1ns/1ps
module extra_fifo_dma_transfer_tb_top
   import efdt_pkg::*;
;
   logic mclk, srst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
   logic arready, rvalid, xfifoValid, xfifoKind, dmaValid, dmaReady, dmaStream, dmaError;
   logic hostEvent, stall;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, dmaAddr;
   logic [1:0] bresp, rresp;
   logic [63:0] xfifoData, dmaData, lastD;
   logic [65:0] rexp;
   logic [96:0] beatQ[$];
   logic [65:0] readQ[$];
   int mismatches, checked, events;
   integer seed = 32'hab7c_365e;

   efdt_extra_dma #(.MS_CYCLES(4)) u_efdt_extra_dma (.mclk, .srst, .awvalid, .awready,
      .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid,
      .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .xfifoValid, .xfifoKind,
      .xfifoData, .dmaValid, .dmaReady, .dmaAddr, .dmaData, .dmaStream, .dmaError, .hostEvent);
   efdt_host_mem u_efdt_host_mem (.mclk, .srst, .dmaValid, .stall, .dmaReady);

   initial begin
      mclk = 1'h0;
      forever #2.5 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input bit ok, input string m);
      checked++;
      if (!ok) begin
         mismatches++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask : check

   task automatic complete_run;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run

   // Both channels are offered together and released each on its own take
   task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
      bit a, w;
      a = 0;
      w = 0;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      awaddr <= {i, 2'h0};
      wdata <= d;
      while (!(a && w)) begin
         @(posedge mclk);
         a |= awready;
         w |= wready;
         if (a) awvalid <= 1'h0;
         if (w) wvalid <= 1'h0;
      end
      // Raised only after the takes, so back-to-back writes never drive it twice in one step
      bready <= 1'h1;
      do @(posedge mclk); while (!bvalid);
      bready <= 1'h0;
      check(bresp === e, "write response");
   endtask : wr

   task automatic rd(input logic [9:0] i, input logic [31:0] m, v,
      input logic [1:0] e = RESP_OKAY);
      readQ.push_back({e, m, v});
      arvalid <= 1'h1;
      araddr <= {i, 2'h0};
      do @(posedge mclk); while (!arready);
      arvalid <= 1'h0;
      rready <= 1'h1;
      do @(posedge mclk); while (!rvalid);
      rready <= 1'h0;
   endtask : rd

   // Leaves the entry strobe high so back-to-back calls stay one driver per step
   task automatic push(input int n, input logic k, input logic [31:0] a);
      for (int j = 0; j < n; j++) begin
         lastD = {$random(seed), $random(seed)};
         xfifoValid <= 1'h1;
         xfifoKind <= k;
         xfifoData <= lastD;
         if (a != 0) beatQ.push_back({a + 8 * j, lastD, k});
         @(posedge mclk);
      end
   endtask : push

   task automatic drain;
      xfifoValid <= 1'h0;
      for (int k = 0; k < 400 && beatQ.size() > 0; k++) @(posedge mclk);
      check(beatQ.size() == 0, "beats missing");
      repeat (4) @(posedge mclk);
   endtask : drain
   ////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      if (hostEvent) events++;
      if (dmaValid && dmaReady) begin
         if (beatQ.size() == 0) check(0, "unexpected beat");
         else check({dmaAddr, dmaData, dmaStream} === beatQ.pop_front(), "beat");
      end
      if (rvalid && rready) begin
         rexp = readQ.pop_front();
         check((rdata & rexp[63:32]) === (rexp[31:0] & rexp[63:32])
            && rresp === rexp[65:64], "read");
      end
   end

   initial begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      $display("FAIL %0t timeout", $time);
      complete_run();
   end

   initial begin
      srst = 1'h1;
      {awvalid, wvalid, bready, arvalid, rready, xfifoValid, xfifoKind, dmaError, stall} = '0;
      {awaddr, araddr, wdata, xfifoData} = '0;
      repeat (5) @(posedge mclk);
      srst <= 1'h0;
      @(posedge mclk);
      wr(IDX_STATUS, 32'h0000_0000, RESP_SLVERR);
      rd(IDX_COMMAND, '1, 32'h0000_0000, RESP_SLVERR);
      rd(10'h3ff, '1, 32'h0000_0000, RESP_SLVERR);
      wr(IDX_NOTIFY, 32'h0000_0010);
      for (int s = 0; s < NUM_STREAMS; s++) begin
         wr(IDX_BASE[s], 32'h0000_2000 >> s);
         wr(IDX_BUF_LEN[s], 32'h0000_0040);
      end
      stall <= 1'h1;
      wr(IDX_COMMAND, CMD_EXTRA_START);
      rd(IDX_STAMP_USER_LEN, '1, 32'h0000_0000);
      rd(IDX_STATUS, 32'h0000_0001, 32'h0000_0001);
      wr(IDX_TIMEOUT, 32'h0000_0001);
      wr(IDX_COMMAND, CMD_EXTRA_WAIT);
      repeat (12) @(posedge mclk);
      rd(IDX_STATUS, 32'h0000_000c, 32'h0000_0008);
      wr(IDX_TIMEOUT, 32'h0000_0000);
      wr(IDX_COMMAND, CMD_EXTRA_WAIT);
      rd(IDX_STATUS, 32'h0000_0004, 32'h0000_0004);
      push(1, 1'h0, 32'h0000_2000);
      push(3, 1'h1, 32'h0000_1000);
      drain();
      rd(IDX_STAMP_USER_LEN, '1, 32'h0000_0010);
      rd(IDX_SLOW_USER_LEN, '1, 32'h0000_0000);
      rd(IDX_STAMP_USER_POS, '1, 32'h0000_0000);
      rd(IDX_STATUS, 32'h0000_3004, 32'h0000_1000);
      check(events == 1, "event count");
      wr(IDX_STAMP_CARD_LEN, 32'h0000_0010);
      rd(IDX_STAMP_USER_LEN, '1, 32'h0000_0000);
      rd(IDX_STAMP_USER_POS, '1, 32'h0000_0010);
      // Notify zero: only the completed buffer is reported
      wr(IDX_NOTIFY, 32'h0000_0000);
      wr(IDX_STAMP_BUF_LEN, 32'h0000_0010);
      wr(IDX_COMMAND, CMD_EXTRA_STOP | CMD_EXTRA_START);
      rd(IDX_STATUS, 32'h0000_f000, 32'h0000_0000);
      rd(IDX_STAMP_USER_LEN, '1, 32'h0000_0000);
      push(2, 1'h1, 32'h0000_1000);
      drain();
      rd(IDX_STAMP_USER_LEN, '1, 32'h0000_0010);
      rd(IDX_STATUS, 32'h0000_3000, 32'h0000_2000);
      wr(IDX_COMMAND, CMD_EXTRA_POLL);
      rd(IDX_STATUS, 32'h0000_8002, 32'h0000_8000);
      stall <= 1'h0;
      wr(IDX_COMMAND, CMD_EXTRA_STOP | CMD_EXTRA_START);
      rd(IDX_STATUS, 32'h0000_c000, 32'h0000_0000);
      dmaError <= 1'h1;
      @(posedge mclk);
      dmaError <= 1'h0;
      rd(IDX_STATUS, 32'h0000_8000, 32'h0000_8000);
      wr(IDX_COMMAND, CMD_EXTRA_STOP | CMD_EXTRA_POLL);
      rd(IDX_STATUS, 32'h0000_0003, 32'h0000_0002);
      push(1, 1'h1, 32'h0000_0000);
      drain();
      rd(IDX_POLL_LO, '1, lastD[31:0]);
      rd(IDX_POLL_HI, '1, lastD[63:32]);
      push(17, 1'h0, 32'h0000_0000);
      drain();
      rd(IDX_STATUS, 32'h0000_4002, 32'h0000_4000);
      complete_run();
   end
endmodule : extra_fifo_dma_transfer_tb_top
